// file: inc/prox_regs_pkg.sv
// Package of register map, field layout and timing constants for the block.
package prox_regs_pkg;

  // ********************************************************************
  // Register addresses.
  // ********************************************************************
  localparam logic [7:0] ADDR_ANALOG_CTRL = 8'h0f;
  localparam logic [7:0] ADDR_PART_ID     = 8'h12;
  localparam logic [7:0] ADDR_STATUS      = 8'h13;
  localparam logic [7:0] ADDR_RESULT_LO   = 8'h18;
  localparam logic [7:0] ADDR_RESULT_HI   = 8'h19;
  localparam logic [7:0] ADDR_OFFSET      = 8'h1e;

  // ********************************************************************
  // Field positions and masks.
  // ********************************************************************
  localparam int         CTRL_DRIVE_LSB   = 6;
  localparam int         CTRL_DIODE_LSB   = 4;
  localparam int         CTRL_GAIN_LSB    = 2;
  localparam logic [7:0] CTRL_WRITE_MASK  = 8'hfc;
  localparam logic [1:0] DIODE_IR_CHANNEL = 2'h2;
  localparam int         STAT_SAT_BIT     = 6;
  localparam int         STAT_IRQ_BIT     = 5;
  localparam int         STAT_VALID_BIT   = 1;
  localparam int         OFFS_SIGN_BIT    = 7;

  // ********************************************************************
  // Reset values.
  // ********************************************************************
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  OFFSET_RESET    = 8'h00;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  // Identification code; the value is arbitrary.
  localparam logic [7:0]  PART_ID_VALUE   = 8'h5a;

  // ********************************************************************
  // LED drive current in tenths of a milliampere, full and low drive.
  // ********************************************************************
  localparam logic [9:0] DRIVE_FULL_0 = 10'h3e8;
  localparam logic [9:0] DRIVE_FULL_1 = 10'h1f4;
  localparam logic [9:0] DRIVE_FULL_2 = 10'h0fa;
  localparam logic [9:0] DRIVE_FULL_3 = 10'h07d;
  localparam logic [9:0] DRIVE_LOW_0  = 10'h06f;
  localparam logic [9:0] DRIVE_LOW_1  = 10'h038;
  localparam logic [9:0] DRIVE_LOW_2  = 10'h01c;
  localparam logic [9:0] DRIVE_LOW_3  = 10'h00e;
  localparam int         LOW_DRIVE_DIV = 9;

  // ********************************************************************
  // Timing: LED pulses repeat at 62.5 kHz on a 40 MHz clock.
  // ********************************************************************
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int PULSE_PERIOD_NS  = 16000;
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int PULSE_HIGH_CYC   = PULSE_PERIOD_CYC / 2;

endpackage : prox_regs_pkg

// file: design/proximity_sensor_regs.sv
// Register bank, result path and LED pulse timing of the proximity sensor.
`timescale 1ns/100ps

// Operation
// - Bits 7:6 pick LED current 100/50/25/12.5 mA, a ninth on low drive.
// - Bits 5:4 pick photodiode; only code 10 valid, host avoids others.
// - Control bits 3:2 pick gain 1x/2x/4x/8x; bits 1:0 reserved.
// - Read-only identification byte at 0x12; writes ignored.
// - Read-only status at 0x13; bits 7, 4, 3, 2, 0 reserved.
// - Status bit 6 shows saturation; bit 5 shows interrupt asserted.
// - Status bit 1 set once an integration cycle completes.
// - Result is 16 bits; low byte at 0x18, high byte at 0x19.
// - Low-byte read copies high byte to shadow; high read returns it.
// - Shadow stays consistent though conversions land between reads.
// - Offset at 0x1e is sign-magnitude: bit 7 sign, bits 6:0 magnitude.
// - Sign 0 shifts result negative, sign 1 shifts it positive.
// - Offset shift scales with gain, LED drive and pulse count.
// - Low-drive bit divides the selected LED current by nine.
// - Emit the programmed LED pulse count in each accumulation phase.
// - Interrupt when result is below low or above high threshold.
// - Proximity interrupts only while the interrupt mask bit is set.
module proximity_sensor_regs #(
  parameter int RESULT_W = 16
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_raw,
  input  wire logic        i_conv_sat,
  input  wire logic        i_accum_start,
  input  wire logic [7:0]  i_led_pulse_count,
  input  wire logic        i_low_drive_flag,
  input  wire logic        i_prox_irq_mask,
  input  wire logic [15:0] i_low_thresh,
  input  wire logic [15:0] i_high_thresh,
  input  wire logic        i_irq_clear,
  output logic [1:0]       o_led_current_select,
  output logic [9:0]       o_led_current_tenth_ma,
  output logic [1:0]       o_photodiode_select,
  output logic             o_photodiode_valid,
  output logic [1:0]       o_prox_gain_select,
  output logic             o_led_driver_output,
  output logic             o_prox_irq
);

  // All checks below share the core clock and are off during reset.
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // ********************************************************************
  // Elaboration check.
  // ********************************************************************
  if (RESULT_W != 16) begin : g_bad_width
    $error("proximity_sensor_regs: RESULT_W must be 16");
  end

  // ********************************************************************
  // State.
  // ********************************************************************
  logic [7:0]  ctrl_q;
  logic [7:0]  offset_q;
  logic [15:0] result_q;
  logic [7:0]  shadow_q;
  logic        sat_q;
  logic        valid_q;
  logic        irq_q;
  logic [7:0]  rdata_d;
  logic [7:0]  status_w;
  logic [17:0] shift_raw;
  logic [17:0] shift_amt;
  logic [18:0] adj_sum;
  logic [15:0] result_d;
  logic        clamp_hi;
  logic [7:0]  pulses_left_q;
  logic [9:0]  pulse_cyc_q;

  // Control register write; reserved bits 1:0 are never stored.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_q <= prox_regs_pkg::CTRL_RESET;
    end else if (i_reg_wr &&
                 i_reg_addr == prox_regs_pkg::ADDR_ANALOG_CTRL) begin
      ctrl_q <= i_reg_wdata & prox_regs_pkg::CTRL_WRITE_MASK;
    end
  end

  // Offset register write; both sign and magnitude are host owned.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      offset_q <= prox_regs_pkg::OFFSET_RESET;
    end else if (i_reg_wr && i_reg_addr == prox_regs_pkg::ADDR_OFFSET) begin
      offset_q <= i_reg_wdata;
    end
  end

  // ********************************************************************
  // Analog control outputs.
  // ********************************************************************
  // Drive current table; low drive gives roughly one ninth of full drive.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_led_current_tenth_ma <= prox_regs_pkg::DRIVE_FULL_0;
    end else begin
      unique case (ctrl_q[prox_regs_pkg::CTRL_DRIVE_LSB +: 2])
        2'h0: o_led_current_tenth_ma <= i_low_drive_flag ?
              prox_regs_pkg::DRIVE_LOW_0 : prox_regs_pkg::DRIVE_FULL_0;
        2'h1: o_led_current_tenth_ma <= i_low_drive_flag ?
              prox_regs_pkg::DRIVE_LOW_1 : prox_regs_pkg::DRIVE_FULL_1;
        2'h2: o_led_current_tenth_ma <= i_low_drive_flag ?
              prox_regs_pkg::DRIVE_LOW_2 : prox_regs_pkg::DRIVE_FULL_2;
        2'h3: o_led_current_tenth_ma <= i_low_drive_flag ?
              prox_regs_pkg::DRIVE_LOW_3 : prox_regs_pkg::DRIVE_FULL_3;
      endcase
    end
  end

  // Field outputs are flopped copies so the analog side sees clean levels.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_led_current_select <= 2'h0;
      o_photodiode_select  <= 2'h0;
      o_photodiode_valid   <= 1'b0;
      o_prox_gain_select   <= 2'h0;
    end else begin
      o_led_current_select <= ctrl_q[prox_regs_pkg::CTRL_DRIVE_LSB +: 2];
      o_photodiode_select  <= ctrl_q[prox_regs_pkg::CTRL_DIODE_LSB +: 2];
      // Reserved diode codes are the host's fault; flag them, do not fix.
      o_photodiode_valid   <= ctrl_q[prox_regs_pkg::CTRL_DIODE_LSB +: 2] ==
                              prox_regs_pkg::DIODE_IR_CHANNEL;
      o_prox_gain_select   <= ctrl_q[prox_regs_pkg::CTRL_GAIN_LSB +: 2];
    end
  end

  // ********************************************************************
  // Offset compensation.
  // ********************************************************************
  // Shift grows with gain and pulses, halves per drive step, ninth on low.
  always_comb begin
    shift_raw = 18'({offset_q[6:0], 3'b000} >> (3 - ctrl_q[3:2]))
                * 18'(i_led_pulse_count) >> 3;
    shift_amt = shift_raw >> ctrl_q[prox_regs_pkg::CTRL_DRIVE_LSB +: 2];
    if (i_low_drive_flag) begin
      shift_amt = 18'(shift_amt / prox_regs_pkg::LOW_DRIVE_DIV);
    end
    if (offset_q[prox_regs_pkg::OFFS_SIGN_BIT]) begin
      adj_sum = {3'b000, i_conv_raw} + {1'b0, shift_amt};
    end else begin
      adj_sum = {3'b000, i_conv_raw} - {1'b0, shift_amt};
    end
    clamp_hi = 1'b0;
    if (adj_sum[18]) begin
      result_d = 16'h0000;
    end else if (adj_sum[17:16] != 2'b00) begin
      result_d = 16'hffff;
      clamp_hi = 1'b1;
    end else begin
      result_d = adj_sum[15:0];
    end
  end

  // Result, saturation and valid flags update on each finished conversion.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      result_q <= prox_regs_pkg::RESULT_RESET;
      sat_q    <= 1'b0;
      valid_q  <= 1'b0;
    end else if (i_conv_done) begin
      result_q <= result_d;
      sat_q    <= i_conv_sat | clamp_hi;
      valid_q  <= 1'b1;
    end
  end

  // Interrupt flag; a new event in the clear cycle wins over the clear.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else if (i_conv_done && i_prox_irq_mask &&
                 (result_d < i_low_thresh || result_d > i_high_thresh)) begin
      irq_q <= 1'b1;
    end else if (i_irq_clear) begin
      irq_q <= 1'b0;
    end
  end

  assign o_prox_irq = irq_q;

  // ********************************************************************
  // Read path with high-byte shadow.
  // ********************************************************************
  assign status_w = {1'b0, sat_q, irq_q, 3'b000, valid_q, 1'b0};

  // Shadow is loaded only by a low-byte read, so later results cannot tear.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      shadow_q <= 8'h00;
    end else if (i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_RESULT_LO) begin
      shadow_q <= result_q[15:8];
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    unique case (i_reg_addr)
      prox_regs_pkg::ADDR_ANALOG_CTRL: rdata_d = ctrl_q;
      prox_regs_pkg::ADDR_PART_ID:
        rdata_d = prox_regs_pkg::PART_ID_VALUE;
      prox_regs_pkg::ADDR_STATUS:      rdata_d = status_w;
      prox_regs_pkg::ADDR_RESULT_LO:   rdata_d = result_q[7:0];
      prox_regs_pkg::ADDR_RESULT_HI:   rdata_d = shadow_q;
      prox_regs_pkg::ADDR_OFFSET:      rdata_d = offset_q;
      default:                         rdata_d = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end
  end

  // ********************************************************************
  // LED pulse train.
  // ********************************************************************
  // Each accumulation start loads the count; pulses run at 62.5 kHz.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pulses_left_q <= 8'h00;
      pulse_cyc_q   <= 10'h000;
    end else if (i_accum_start) begin
      pulses_left_q <= i_led_pulse_count;
      pulse_cyc_q   <= 10'h000;
    end else if (pulses_left_q != 8'h00) begin
      if (pulse_cyc_q == 10'(prox_regs_pkg::PULSE_PERIOD_CYC - 1)) begin
        pulse_cyc_q   <= 10'h000;
        pulses_left_q <= pulses_left_q - 8'h01;
      end else begin
        pulse_cyc_q <= pulse_cyc_q + 10'h001;
      end
    end
  end

  // Driver output is flopped to keep glitches off the LED switch.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_led_driver_output <= 1'b0;
    end else begin
      o_led_driver_output <= !i_accum_start && pulses_left_q != 8'h00 &&
        pulse_cyc_q < 10'(prox_regs_pkg::PULSE_HIGH_CYC);
    end
  end

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  ctrl_reserved_a: assert property (
    i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_ANALOG_CTRL
    |=> o_reg_rdata[1:0] == 2'b00)
    else $error("control reserved bits read nonzero");

  id_readback_a: assert property (
    i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_PART_ID
    |=> o_reg_rdata == prox_regs_pkg::PART_ID_VALUE)
    else $error("identification byte wrong");

  status_reserved_a: assert property (
    i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_STATUS
    |=> (o_reg_rdata & 8'h9d) == 8'h00 && o_reg_rdata[5] == $past(irq_q))
    else $error("status read wrong");

  shadow_capture_a: assert property (
    i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_RESULT_LO
    ##1 i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_RESULT_HI
    |=> o_reg_rdata == $past(result_q[15:8], 2))
    else $error("high byte not from low read sample");

  shadow_stable_a: assert property (
    !(i_reg_rd && i_reg_addr == prox_regs_pkg::ADDR_RESULT_LO)
    |=> $stable(shadow_q))
    else $error("shadow changed without low read");

  valid_set_a: assert property (
    i_conv_done |=> valid_q ##1 valid_q)
    else $error("valid flag not set after conversion");

  irq_masked_a: assert property (
    $rose(irq_q) |-> $past(i_prox_irq_mask) && $past(i_conv_done))
    else $error("interrupt raised while masked");

  offset_dir_a: assert property (
    i_conv_done && !offset_q[7] |=> result_q <= $past(i_conv_raw))
    else $error("negative offset raised result");

  low_drive_a: assert property (
    i_low_drive_flag ##1 i_low_drive_flag |-> o_led_current_tenth_ma < 10'h070)
    else $error("low drive current too high");

  pulse_idle_a: assert property (
    pulses_left_q == 8'h00 && !i_accum_start |=> !o_led_driver_output)
    else $error("LED pulse with no pulses left");

endmodule : proximity_sensor_regs

// file: verification/prox_host_model.sv
// Host model that drives the byte register port as the bus master would.
`timescale 1ns/100ps

module prox_host_model (
  input  wire logic       i_core_clk,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_rd,
  input  wire logic [7:0] i_reg_rdata
);
  // Idle bus at time zero: both strobes low.
  initial begin
    o_reg_addr  = 8'hff;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd    = 1'b0;
  end

  // One byte written; the strobe is held across exactly one edge.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~d;
  endtask : write

  // Reads one or two bytes back to back with the address stepping up.
  // A two-byte burst keeps the result pair coherent.
  task automatic read(input logic [7:0] a, input int n,
                      output logic [15:0] d);
    d = 16'h0000;
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge i_core_clk);
      if (k == n - 1) begin
        o_reg_rd <= 1'b0;
      end else begin
        o_reg_addr <= a + 8'h01;
      end
      #1;
      d[8*k +: 8] = i_reg_rdata;
    end
  endtask : read
endmodule : prox_host_model

// file: verification/test_proximity_sensor_regs.sv
// Self-checking bench for the proximity sensor register bank.
`timescale 1ns/100ps

module test_proximity_sensor_regs;
  // ******************************************************************
  // Signals and the table of control settings.
  // ******************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic       ld;
    logic [9:0] tenth;
    logic       dv;
  } row_t;

  row_t rows [8] = '{'{8'h23, 1'b0, 10'h3e8, 1'b1},
                     '{8'h44, 1'b0, 10'h1f4, 1'b0},
                     '{8'h99, 1'b0, 10'h0fa, 1'b0},
                     '{8'hfe, 1'b0, 10'h07d, 1'b0},
                     '{8'h24, 1'b1, 10'h06f, 1'b1},
                     '{8'h68, 1'b1, 10'h038, 1'b1},
                     '{8'hac, 1'b1, 10'h01c, 1'b1},
                     '{8'he0, 1'b1, 10'h00e, 1'b1}};
  logic [7:0] ra [7] = '{8'h0f, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1e, 8'h40};
  logic [7:0] re [7] = '{8'h00, prox_regs_pkg::PART_ID_VALUE, 8'h00,
                         8'h00, 8'h00, 8'h00, 8'h00};
  logic        core_clk, rst, wr, rd, conv_done, conv_sat, accum_start;
  logic        low_drive, irq_mask, irq_clear, dvalid, led_out, irq;
  logic [7:0]  addr, wdata, rdata, pulse_cnt;
  logic [15:0] conv_raw, low_th, high_th, d, r1, r3;
  logic [1:0]  led_sel, dsel, gain;
  logic [9:0]  tenth;
  int          n_mismatch, checks, cycles, hi_cnt, rises;
  logic        prev;

  proximity_sensor_regs i_proximity_sensor_regs (
    .i_core_clk(core_clk), .i_rst(rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_conv_done(conv_done), .i_conv_raw(conv_raw),
    .i_conv_sat(conv_sat), .i_accum_start(accum_start),
    .i_led_pulse_count(pulse_cnt), .i_low_drive_flag(low_drive),
    .i_prox_irq_mask(irq_mask), .i_low_thresh(low_th),
    .i_high_thresh(high_th), .i_irq_clear(irq_clear),
    .o_led_current_select(led_sel), .o_led_current_tenth_ma(tenth),
    .o_photodiode_select(dsel), .o_photodiode_valid(dvalid),
    .o_prox_gain_select(gain), .o_led_driver_output(led_out),
    .o_prox_irq(irq));

  prox_host_model i_prox_host_model (
    .i_core_clk(core_clk), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_wdata(wdata), .o_reg_rd(rd), .i_reg_rdata(rdata));

  // The clock toggles every half period of 25 ns.
  always #12.5 core_clk = ~core_clk;

  // A hang is cut short well past the few thousand cycles the run needs.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Compares one value; case equality lets no unknown pass.
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One conversion pulse, then one edge for the result to land.
  task automatic conv(input logic [15:0] raw, input logic sat);
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_raw  <= raw;
    conv_sat  <= sat;
    @(posedge core_clk);
    conv_done <= 1'b0;
    @(posedge core_clk);
  endtask : conv

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    // The host model alone drives the strobes, so they stay out of here.
    {core_clk, conv_done, conv_sat, accum_start} = 4'h0;
    {low_drive, irq_mask, irq_clear} = 3'h0;
    {conv_raw, low_th, high_th} = 48'h0;
    pulse_cnt = 8'h08;
    rst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("tenth_rst", 16'h03e8, 16'(tenth));
    // Release on an edge, so reset is seen at exactly five edges.
    @(posedge core_clk);
    rst <= 1'b0;
    // Read-only places must ignore writes, so reset values survive.
    foreach (ra[k]) i_prox_host_model.write(ra[k], 8'hff);
    i_prox_host_model.write(8'h0f, 8'h00);
    i_prox_host_model.write(8'h1e, 8'h00);
    foreach (ra[k]) begin
      i_prox_host_model.read(ra[k], 1, d);
      chk("reg_rd", {8'h00, re[k]}, d);
    end
    $display("Test reset done");
    foreach (rows[k]) begin
      low_drive <= rows[k].ld;
      i_prox_host_model.write(8'h0f, rows[k].ctrl);
      repeat (3) @(posedge core_clk);
      #1;
      chk("drive", 16'(rows[k].ctrl[7:6]), 16'(led_sel));
      chk("tenth", 16'(rows[k].tenth), 16'(tenth));
      chk("diode", 16'(rows[k].ctrl[5:4]), 16'(dsel));
      chk("dvalid", 16'(rows[k].dv), 16'(dvalid));
      chk("gain", 16'(rows[k].ctrl[3:2]), 16'(gain));
      i_prox_host_model.read(8'h0f, 1, d);
      chk("ctrl_rb", {8'h00, rows[k].ctrl & 8'hfc}, d);
    end
    $display("Test control table done");
    low_drive <= 1'b0;
    irq_mask  <= 1'b1;
    low_th    <= 16'h0100;
    high_th   <= 16'h0200;
    conv(16'h1234, 1'b1);
    chk("irq_set", 16'h0001, 16'(irq));
    i_prox_host_model.read(8'h13, 1, d);
    chk("status", 16'h0062, d);
    i_prox_host_model.read(8'h18, 2, d);
    chk("result", 16'h1234, d);
    i_prox_host_model.read(8'h18, 1, d);
    conv(16'habcd, 1'b0);
    i_prox_host_model.read(8'h19, 1, d);
    chk("shadow", 16'h0012, d);
    @(posedge core_clk);
    irq_clear <= 1'b1;
    @(posedge core_clk);
    irq_clear <= 1'b0;
    irq_mask  <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("irq_clr", 16'h0000, 16'(irq));
    conv(16'h0050, 1'b0);
    i_prox_host_model.read(8'h13, 1, d);
    chk("masked", 16'h0002, d);
    // An event in the very cycle of a clear must keep the flag set.
    irq_mask <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_raw  <= 16'h0300;
    irq_clear <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    irq_clear <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("irq_win", 16'h0001, 16'(irq));
    $display("Test status and result done");
    i_prox_host_model.write(8'h0f, 8'h2c);
    i_prox_host_model.write(8'h1e, 8'hff);
    conv(16'h1000, 1'b0);
    i_prox_host_model.read(8'h18, 2, r1);
    chk("off_pos", 16'h0001, 16'(r1 > 16'h1000));
    i_prox_host_model.read(8'h1e, 1, d);
    chk("off_rb", 16'h00ff, d);
    // The host steers the offset from what it has just measured.
    i_prox_host_model.write(8'h1e, (r1 > 16'h1000) ? 8'h7f : 8'hff);
    conv(16'h1000, 1'b0);
    i_prox_host_model.read(8'h18, 2, d);
    chk("off_neg", 16'h0001, 16'(d < 16'h1000));
    i_prox_host_model.write(8'h0f, 8'h20);
    i_prox_host_model.write(8'h1e, 8'hff);
    conv(16'h1000, 1'b0);
    i_prox_host_model.read(8'h18, 2, r3);
    chk("off_gain", 16'h0001, 16'(r3 > 16'h1000 && r3 < r1));
    $display("Test offset done");
    // Two pulses of 320 high cycles each; the window covers both fully.
    pulse_cnt   <= 8'h02;
    @(posedge core_clk);
    accum_start <= 1'b1;
    @(posedge core_clk);
    accum_start <= 1'b0;
    prev = 1'b0;
    repeat (2000) begin
      @(posedge core_clk);
      #1;
      if (led_out === 1'b1) hi_cnt++;
      if (led_out === 1'b1 && prev === 1'b0) rises++;
      prev = led_out;
    end
    chk("pulses", 16'd2, 16'(rises));
    chk("hi_cycles", 16'h0280, 16'(hi_cnt));
    $display("Test led pulses done");
    finish_test();
  end
endmodule : test_proximity_sensor_regs
